// ===== rtl/acs_core.sv
// What this block does
// - mode 00: start pulse runs timed scan
// - scan channels 0 to scan_last, power down, end-flag low
// - temperature result first, 12-bit wide
// - mode 01: start low wakes and tracks
// - temperature timed inside, start held 40us
// - mode 01: rising edge converts, then shutdown
// - end-flag low until select or start low
// - averaged entry written, then next channel
// - mode 01 temperature after first rising edge
// - mode 10 default; command byte starts scan
// - mode 10: end-flag low until select low
// - mode 11: one sample per command, sclk
// - two idle bytes power analog down unless the last command was temperature
// - bias keep-on bit holds bias powered
// - mode 11 temperature in last two bytes
// - load pin low transfers dac registers
// - result two bytes, zeros, sub-bits
//
// Purpose: conversion sequencing on the internal clock, mode 11 engine inside
// Assumes: mclk stands in for the internal oscillator; fifo storage lives outside
// Notes:   a 40ns start pulse is shorter than mclk, so short pulses may be missed
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_core
    import acs_pkg::*;
#(
    parameter int CONV_CYC = 40
)
(
    // clock, reset, enable
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // configuration
    input  wire logic [1:0]             clock_mode_select,
    input  wire logic [1:0]             ref_mode,
    input  wire logic                   temp_req,
    input  wire logic [`ACS_CHAN_W-1:0] scan_last,
    input  wire logic [2:0]             avg_log2,
    input  wire logic                   bias_keep_on,
    input  wire logic                   conv_cmd,
    // pins
    input  wire logic                   convert_start_n,
    input  wire logic                   cs_n,
    input  wire logic                   dac_load_n,
    input  wire logic                   sclk,
    input  wire logic                   sdi,
    output logic                        eoc_n,
    output logic                        dout,
    // analog side
    input  wire logic [`ACS_RES_W-1:0]  adc_result,
    input  wire logic [`ACS_TEMP_W-1:0] temp_result,
    input  wire logic                   sar_bit,
    input  wire logic [`ACS_TEMP_W-1:0] temp_result_sclk,
    output logic [`ACS_CHAN_W-1:0]      adc_channel,
    output logic                        adc_power,
    output logic                        adc_track,
    output logic                        adc_convert,
    output logic                        temp_measure,
    output logic                        analog_off,
    output logic                        bias_off,
    output logic                        sclk_conv_active,
    // result fifo write
    output logic                        fifo_we,
    output logic                        fifo_temp,
    output logic [`ACS_FIFO_W-1:0]      fifo_data,
    // dac
    output logic                        dac_transfer
);
    localparam int ACQ_CYC    = (`ACS_ACQ_NS * `ACS_MCLK_MHZ + 999) / 1000;
    localparam int SAMPLE_CYC = (`ACS_SAMPLE_NS * `ACS_MCLK_MHZ + 999) / 1000;
    localparam int REF_CYC    = (`ACS_REF_NS * `ACS_MCLK_MHZ + 999) / 1000;
    localparam int TEMP_CYC   = (`ACS_TEMP_NS * `ACS_MCLK_MHZ + 999) / 1000;
    localparam logic [`ACS_CNT_W-1:0] ACQ_LD    = `ACS_CNT_W'(ACQ_CYC - 1);
    localparam logic [`ACS_CNT_W-1:0] SAMPLE_LD = `ACS_CNT_W'(SAMPLE_CYC - 1);
    localparam logic [`ACS_CNT_W-1:0] REF_LD    = `ACS_CNT_W'(REF_CYC - 1);
    localparam logic [`ACS_CNT_W-1:0] TEMP_LD   = `ACS_CNT_W'(TEMP_CYC - 1);
    localparam logic [`ACS_CNT_W-1:0] CONV_LD   = `ACS_CNT_W'(CONV_CYC - 1);

    // sync bit positions
    localparam int P_CNV = 0;
    localparam int P_CS  = 1;
    localparam int P_LD  = 2;

    acs_core_t r;
    acs_core_t n;

    logic                      cnv_fall;
    logic                      cnv_rise;
    logic                      cs_fall;
    logic                      mode_cnv;
    logic                      mode_ext;
    logic                      mode_cmd;
    logic                      cnt_done;
    logic                      ref_wait;
    logic [`ACS_NAVG_W-1:0]    navg_tgt;
    logic [`ACS_ACC_W-1:0]     acc_sum;
    logic [`ACS_ACC_W-1:0]     acc_avg;

    assign mode_cnv = (clock_mode_select == `ACS_MODE_CNV);
    assign mode_ext = (clock_mode_select == `ACS_MODE_EXTACQ);
    assign mode_cmd = (clock_mode_select == `ACS_MODE_CMD);
    assign cnv_fall = !r.sync2[P_CNV] && r.prev[P_CNV];
    assign cnv_rise = r.sync2[P_CNV] && !r.prev[P_CNV];
    assign cs_fall  = !r.sync2[P_CS] && r.prev[P_CS];
    assign cnt_done = (r.cnt == '0);
    assign ref_wait = (ref_mode == `ACS_REF_INT_A) || (ref_mode == `ACS_REF_INT_B);
    assign navg_tgt = `ACS_NAVG_W'(1) << avg_log2;
    assign acc_sum  = r.acc + `ACS_ACC_W'(adc_result);
    assign acc_avg  = acc_sum >> avg_log2;

    always_comb begin
        n = r;
        if (ce) begin
            n.sync1   = {dac_load_n, cs_n, convert_start_n};
            n.sync2   = r.sync1;
            n.prev    = r.sync2;
            n.fifo_we = 1'b0;
            n.dac_xfer = !r.sync2[P_LD]; // follows while held low
            if (!cnt_done) begin
                n.cnt = r.cnt - `ACS_CNT_W'(1);
            end
            // select low ends the flag in every mode unless a scan, conversion or temperature reading ends that cycle; start low only in pin-started modes
            if (cs_fall || (cnv_fall && (mode_cnv || mode_ext))) begin
                n.eoc_n = 1'b1;
            end
            unique case (r.st)
                ST_IDLE: begin
                    // start pin is looked at only in modes 00 and 01
                    if ((mode_cnv && cnv_rise) || (mode_cmd && conv_cmd)) begin
                        // whole timed scan from pulse or command byte
                        n.st        = ST_WAKE;
                        n.scan_run  = 1'b1;
                        n.adc_on    = 1'b1;
                        n.eoc_n     = 1'b1;
                        n.chan      = '0;
                        n.navg      = '0;
                        n.acc       = '0;
                        n.temp_pend = temp_req;
                        n.cnt       = ref_wait ? REF_LD : '0;
                    end else if (mode_ext && conv_cmd) begin
                        // command arms a paced scan; first rising edge does temperature
                        n.scan_run  = 1'b0;
                        n.chan      = '0;
                        n.navg      = '0;
                        n.acc       = '0;
                        n.temp_pend = temp_req;
                    end else if (mode_ext && cnv_fall) begin
                        n.st     = ST_ACQ; // wake and track while low
                        n.adc_on = 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (cnt_done) begin
                        n.st  = r.temp_pend ? ST_TEMP : ST_ACQ;
                        n.cnt = r.temp_pend ? TEMP_LD : ACQ_LD;
                    end
                end
                ST_TEMP: begin
                    // reference and temperature timed internally
                    if (cnt_done) begin
                        n.fifo_we   = 1'b1;
                        n.fifo_temp = 1'b1;
                        n.fifo_data = temp_result; // ahead of channel results
                        n.temp_pend = 1'b0;
                        if (r.scan_run) begin
                            n.st  = ST_ACQ;
                            n.cnt = ACQ_LD;
                        end else begin
                            n.st     = ST_IDLE;
                            n.adc_on = 1'b0;
                            n.eoc_n  = 1'b0;
                        end
                    end
                end
                ST_ACQ: begin
                    if (!r.scan_run) begin
                        if (cnv_rise) begin
                            n.st  = r.temp_pend ? ST_TEMP : ST_SAMPLE;
                            n.cnt = r.temp_pend ? TEMP_LD : SAMPLE_LD;
                        end
                    end else if (cnt_done) begin
                        n.st  = ST_SAMPLE;
                        n.cnt = SAMPLE_LD;
                    end
                end
                ST_SAMPLE: begin
                    if (cnt_done) begin
                        n.st  = ST_CONV;
                        n.cnt = CONV_LD;
                    end
                end
                ST_CONV: begin
                    if (cnt_done) begin
                        n.st = ST_STORE;
                    end
                end
                ST_STORE: begin
                    n.acc  = acc_sum;
                    n.navg = r.navg + `ACS_NAVG_W'(1);
                    if (r.navg + `ACS_NAVG_W'(1) == navg_tgt) begin
                        // one averaged entry, then step the multiplexer
                        n.fifo_we   = 1'b1;
                        n.fifo_temp = 1'b0;
                        n.fifo_data = `ACS_FIFO_W'(acc_avg[`ACS_RES_W-1:0]);
                        n.navg      = '0;
                        n.acc       = '0;
                        n.chan      = (r.chan == scan_last) ? '0 : r.chan + `ACS_CHAN_W'(1);
                    end
                    if (r.scan_run && !(r.navg + `ACS_NAVG_W'(1) == navg_tgt && r.chan == scan_last)) begin
                        n.st  = ST_ACQ;
                        n.cnt = ACQ_LD;
                    end else begin
                        // finished: power down and drop the flag; this set beats a clear
                        n.st       = ST_IDLE;
                        n.scan_run = 1'b0;
                        n.adc_on   = 1'b0;
                        n.eoc_n    = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r       <= '0;
            r.st    <= ST_IDLE;
            r.sync1 <= 3'h7;
            r.sync2 <= 3'h7;
            r.prev  <= 3'h7;
            r.eoc_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign eoc_n        = r.eoc_n;
    assign adc_channel  = r.chan;
    assign adc_power    = r.adc_on;
    assign adc_track    = (r.st == ST_ACQ);
    assign adc_convert  = (r.st == ST_SAMPLE) || (r.st == ST_CONV);
    assign temp_measure = (r.st == ST_TEMP);
    assign fifo_we      = r.fifo_we;
    assign fifo_temp    = r.fifo_temp;
    assign fifo_data    = r.fifo_data;
    assign dac_transfer = r.dac_xfer;

    // mode 11 runs on sclk; config levels are resynchronised inside
    acs_sclk_engine u_sclk (
        .sclk         (sclk),
        .rst          (rst),
        .cs_n         (cs_n),
        .sdi          (sdi),
        .mode_sclk    (clock_mode_select == `ACS_MODE_SCLK),
        .temp_req     (temp_req),
        .bias_keep_on (bias_keep_on),
        .sar_bit      (sar_bit),
        .temp_result  (temp_result_sclk),
        .dout         (dout),
        .analog_off   (analog_off),
        .bias_off     (bias_off),
        .conv_active  (sclk_conv_active)
    );
endmodule

// ===== common/acs_regs.svh
// Purpose: constants of the adc conversion sequencer
// Assumes: included by its bare name
// Notes:   times in ns as printed; cycle counts derived in the core
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_MCLK_MHZ    20
`define ACS_CNV_LOW_NS  40
`define ACS_ACQ_NS      1400
`define ACS_SAMPLE_NS   500
`define ACS_REF_NS      45000
`define ACS_TEMP_NS     53100
`define ACS_MODE_CNV    2'h0
`define ACS_MODE_EXTACQ 2'h1
`define ACS_MODE_CMD    2'h2
`define ACS_MODE_SCLK   2'h3
`define ACS_REF_INT_A   2'h0
`define ACS_REF_INT_B   2'h2
`define ACS_RES_W       10
`define ACS_TEMP_W      12
`define ACS_FIFO_W      12
`define ACS_CNT_W       11
`define ACS_ACC_W       14
`define ACS_NAVG_W      5
`define ACS_CHAN_W      4
`define ACS_LEAD_ZEROS  4
`define ACS_WORD_BITS   16
`define ACS_BYTE_LAST   3'h7
`define ACS_TEMP_CYCLES 192
`define ACS_WCNT_W      8
`define ACS_NOP_LIMIT   2'h2
`endif

// ===== common/acs_pkg.sv
// Purpose: types of the adc conversion sequencer
// Assumes: acs_regs.svh on the include path
// Notes:   all state of each module is one struct
`include "acs_regs.svh"
package acs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAKE, ST_TEMP, ST_ACQ, ST_SAMPLE, ST_CONV, ST_STORE
    } acs_state_t;

    typedef struct packed {
        acs_state_t               st;
        logic [2:0]               sync1;
        logic [2:0]               sync2;
        logic [2:0]               prev;
        logic [`ACS_CNT_W-1:0]    cnt;
        logic [`ACS_CHAN_W-1:0]   chan;
        logic [`ACS_NAVG_W-1:0]   navg;
        logic [`ACS_ACC_W-1:0]    acc;
        logic                     temp_pend;
        logic                     scan_run;
        logic                     eoc_n;
        logic                     adc_on;
        logic                     fifo_we;
        logic                     fifo_temp;
        logic [`ACS_FIFO_W-1:0]   fifo_data;
        logic                     dac_xfer;
    } acs_core_t;

    typedef struct packed {
        logic [2:0]               sync1;
        logic [2:0]               sync2;
        logic [2:0]               bitcnt;
        logic [7:0]               shift;
        logic                     busy;
        logic                     temp_mode;
        logic [`ACS_WCNT_W-1:0]   wcnt;
        logic [1:0]               nop_cnt;
        logic [`ACS_WORD_BITS-1:0] tword;
        logic                     dout;
        logic                     analog_off;
        logic                     bias_off;
    } acs_sclk_t;
endpackage

// ===== rtl/acs_sclk_engine.sv
// Purpose: serial-clocked single conversion engine (clock mode 11)
// Assumes: sar_bit and temp_result are produced on the sclk domain
// Notes:   state holds while sclk stands still between frames
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_sclk_engine
    import acs_pkg::*;
(
    // link clock and reset
    input  wire logic                   sclk,
    input  wire logic                   rst,
    // serial pins
    input  wire logic                   cs_n,
    input  wire logic                   sdi,
    // configuration from the core clock domain
    input  wire logic                   mode_sclk,
    input  wire logic                   temp_req,
    input  wire logic                   bias_keep_on,
    // analog side on sclk
    input  wire logic                   sar_bit,
    input  wire logic [`ACS_TEMP_W-1:0] temp_result,
    // outputs
    output logic                        dout,
    output logic                        analog_off,
    output logic                        bias_off,
    output logic                        conv_active
);
    localparam logic [`ACS_WCNT_W-1:0] WORD_LAST = `ACS_WCNT_W'(`ACS_WORD_BITS - 1);
    localparam logic [`ACS_WCNT_W-1:0] TEMP_LAST = `ACS_WCNT_W'(`ACS_TEMP_CYCLES - 1);
    localparam logic [`ACS_WCNT_W-1:0] TEMP_LOAD = `ACS_WCNT_W'(`ACS_TEMP_CYCLES - `ACS_WORD_BITS - 1);
    localparam logic [`ACS_WCNT_W-1:0] LEAD_END  = `ACS_WCNT_W'(`ACS_LEAD_ZEROS);

    acs_sclk_t r;
    acs_sclk_t n;
    logic [7:0] byte_nxt;
    logic       byte_end;

    always_comb begin
        n        = r;
        byte_nxt = {r.shift[6:0], sdi};
        byte_end = (r.bitcnt == `ACS_BYTE_LAST);
        n.sync1  = {bias_keep_on, temp_req, mode_sclk};
        n.sync2  = r.sync1;
        // bytes framed in every mode; the mode sync lags two sclk edges
        if (!cs_n) begin
            n.shift  = byte_nxt;
            n.bitcnt = r.bitcnt + 3'h1;
        end
        if (!cs_n && r.sync2[0]) begin
            if (r.busy) begin
                n.wcnt = r.wcnt + `ACS_WCNT_W'(1);
                if (!r.temp_mode) begin
                    // four leading zeros, ten bits, two sub-bits; bits change on rising sclk
                    n.dout = (r.wcnt < LEAD_END) ? 1'b0 : sar_bit;
                    if (r.wcnt == WORD_LAST) begin
                        n.busy = 1'b0;
                    end
                end else begin
                    // temperature shows in the last two of the 24 zero bytes
                    if (r.wcnt == TEMP_LOAD) begin
                        n.tword = {{`ACS_LEAD_ZEROS{1'b0}}, temp_result};
                    end else if (r.wcnt > TEMP_LOAD) begin
                        n.dout  = r.tword[`ACS_WORD_BITS-1];
                        n.tword = {r.tword[`ACS_WORD_BITS-2:0], 1'b0};
                    end
                    if (r.wcnt == TEMP_LAST) begin
                        n.busy = 1'b0;
                    end
                end
            end
            if (byte_end) begin
                if (byte_nxt != 8'h00) begin
                    // a command byte starts one conversion, no scan or averaging
                    n.busy       = 1'b1;
                    n.wcnt       = '0;
                    n.temp_mode  = r.sync2[1];
                    n.nop_cnt    = 2'h0;
                    n.analog_off = 1'b0;
                    n.bias_off   = 1'b0;
                end else begin
                    if (r.nop_cnt != `ACS_NOP_LIMIT) begin
                        n.nop_cnt = r.nop_cnt + 2'h1;
                    end
                    // second idle byte in a row powers the cells down, unless the last command was temperature
                    if (r.nop_cnt == `ACS_NOP_LIMIT - 2'h1 && !(r.busy && r.temp_mode)) begin
                        n.analog_off = 1'b1;
                        n.bias_off   = !r.sync2[2];
                    end
                end
            end
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            r            <= '0;
            r.analog_off <= 1'b1;
            r.bias_off   <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign dout        = r.dout;
    assign analog_off  = r.analog_off;
    assign bias_off    = r.bias_off;
    assign conv_active = r.busy;
endmodule

// ===== testbench/acs_core_checker.sv
// Purpose: port-level checks of the conversion sequencer
// Assumes: bound to acs_core, single mclk domain
// Notes:   pin synchronisers add up to three cycles of delay
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_core_checker (
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst,
    // control and pins
    input wire logic [1:0]             clock_mode_select,
    input wire logic                   conv_cmd,
    input wire logic                   convert_start_n,
    input wire logic                   cs_n,
    input wire logic                   dac_load_n,
    // watched outputs
    input wire logic                   eoc_n,
    input wire logic [`ACS_CHAN_W-1:0] adc_channel,
    input wire logic                   adc_power,
    input wire logic                   adc_convert,
    input wire logic                   fifo_we,
    input wire logic                   fifo_temp,
    input wire logic [`ACS_FIFO_W-1:0] fifo_data,
    input wire logic                   dac_transfer
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    dac_follow_a: assert property ((!dac_load_n) [*4] |-> dac_transfer)
        else $error("dac transfer missing");
    dac_idle_a: assert property (dac_load_n [*4] |-> !dac_transfer)
        else $error("dac transfer without load");
    eoc_hold_a: assert property (!eoc_n && cs_n && $past(cs_n) && convert_start_n
        && $past(convert_start_n) |=> !eoc_n)
        else $error("end flag released early");
    eoc_power_a: assert property ($fell(eoc_n) |-> !adc_power && !adc_convert)
        else $error("end flag before power down");
    busy_flag_a: assert property (adc_power |-> eoc_n)
        else $error("end flag low while powered");
    fifo_pulse_a: assert property (fifo_we |=> !fifo_we)
        else $error("fifo write longer than a cycle");
    fifo_width_a: assert property (fifo_we && !fifo_temp |-> fifo_data[11:10] == 2'h0)
        else $error("adc entry wider than ten bits");
    sclk_nofifo_a: assert property (clock_mode_select == 2'h3 |-> !fifo_we)
        else $error("fifo written in serial clock mode");
    cmd_only_a: assert property (clock_mode_select == 2'h2 && !adc_power && !conv_cmd && !$past(conv_cmd)
        && !$past(conv_cmd, 2) && !$past(conv_cmd, 3) |=> !adc_power)
        else $error("scan started without command");
    chan_stable_a: assert property (adc_convert && $past(adc_convert) |-> $stable(adc_channel))
        else $error("channel moved during conversion");
endmodule

// ===== testbench/acs_host_model.sv
// Purpose: host acting as serial bus master
// Assumes: sclk idles low and runs only inside frames
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/10ps
module acs_host_model (
    // serial pins
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    output logic      sar_bit,
    input  wire logic dout
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        sar_bit = 1'b0;
    end

    // nb bits of b, then nr zero clocks reading dout; w feeds the sar bits
    task automatic xfer(input logic [7:0] b, input int nb, input int nr, input logic [11:0] w,
                        input int hold, output logic [15:0] rx);
        rx = 16'h0;
        #7 cs_n = 1'b0; // select stays high only 7ns between back-to-back frames
        #(7 + hold);
        for (int k = 0; k < nb + nr; k++) begin
            sdi = (k < nb) && b[7 - (k % 8)];
            sar_bit = (k - nb >= 4 && k - nb < 16) ? w[15 - (k - nb)] : ~sar_bit;
            #6 sclk = 1'b1;
            #6 sclk = 1'b0;
            rx = {rx[14:0], dout};
        end
        #7 cs_n = 1'b1; // select gap kept short
        sdi = ~sdi;
    endtask
endmodule

// ===== testbench/acs_core_bench.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: host model drives the serial pins
// Notes:   conversion time shortened to keep the run brief
`timescale 1ns/10ps
`include "acs_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module acs_core_bench;
    logic        mclk, rst, ce, conv_cmd, temp_req, bias_keep_on, convert_start_n, dac_load_n;
    logic [1:0]  clock_mode_select, ref_mode;
    logic [3:0]  scan_last;
    logic [2:0]  avg_log2;
    logic [9:0]  adc_result;
    logic [11:0] temp_result, sar_word;
    logic [15:0] rx;
    logic [12:0] note;
    logic [12:0] exp_q[$];
    wire logic   cs_n, sclk, sdi, sar_bit, eoc_n, dout, analog_off, bias_off, fifo_we, fifo_temp;
    wire logic   adc_power, dac_transfer;
    wire logic [`ACS_CHAN_W-1:0] adc_channel;
    wire logic [`ACS_FIFO_W-1:0] fifo_data;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          seed = 32'h38f2;

    acs_core #(.CONV_CYC(2)) dut (
        .mclk(mclk), .rst(rst), .ce(ce), .clock_mode_select(clock_mode_select), .ref_mode(ref_mode),
        .temp_req(temp_req), .scan_last(scan_last), .avg_log2(avg_log2), .bias_keep_on(bias_keep_on),
        .conv_cmd(conv_cmd), .convert_start_n(convert_start_n), .cs_n(cs_n), .dac_load_n(dac_load_n),
        .sclk(sclk), .sdi(sdi), .eoc_n(eoc_n), .dout(dout), .adc_result(adc_result),
        .temp_result(temp_result), .sar_bit(sar_bit), .temp_result_sclk(sar_word),
        .adc_channel(adc_channel), .adc_power(adc_power), .adc_track(), .adc_convert(), .temp_measure(),
        .analog_off(analog_off), .bias_off(bias_off), .sclk_conv_active(), .fifo_we(fifo_we),
        .fifo_temp(fifo_temp), .fifo_data(fifo_data), .dac_transfer(dac_transfer));
    acs_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sar_bit(sar_bit), .dout(dout));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic wait_eoc();
        for (int k = 0; k < 5000 && eoc_n !== 1'b0; k++) cyc(1);
        `CHK("eoc_n", 1'b0, eoc_n)
    endtask

    // pin held far beyond 40ns so the synchroniser sees it
    task automatic pin_low(input int n);
        convert_start_n = 1'b0;
        cyc(n);
        `CHK("eoc_release", 1'b1, eoc_n)
    endtask

    task automatic expect_scan(input int n);
        if (temp_req) exp_q.push_back({1'b1, temp_result});
        repeat (n) exp_q.push_back({3'h0, adc_result});
    endtask

    task automatic command();
        conv_cmd = 1'b1;
        cyc(1);
        conv_cmd = 1'b0;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    always @(posedge mclk) begin
        if (fifo_we === 1'b1) begin
            note = (exp_q.size() != 0) ? exp_q.pop_front() : 13'bx;
            `CHK("fifo", note, {fifo_temp, fifo_data})
        end
    end

    initial begin
        {ce, rst, conv_cmd, bias_keep_on, convert_start_n, dac_load_n} = 6'b110011;
        clock_mode_select = 2'h2;
        ref_mode = 2'h1;
        scan_last = 4'h1;
        avg_log2 = 3'h0;
        temp_req = 1'b1;
        adc_result = 10'($random(seed));
        temp_result = 12'($random(seed));
        sar_word = 12'h0;
        repeat (5) @(posedge mclk);
        #2 rst = 1'b0;
        `CHK("reset", 6'b100011, {eoc_n, fifo_we, adc_power, dac_transfer, analog_off, bias_off})
        expect_scan(2);
        command();
        wait_eoc();
        convert_start_n = 1'b0;
        cyc(6);
        `CHK("eoc_hold", 1'b0, eoc_n)
        convert_start_n = 1'b1;
        host.xfer(8'h00, 0, 0, sar_word, 150, rx);
        cyc(4);
        `CHK("eoc_cs", 1'b1, eoc_n)
        clock_mode_select = 2'h0;
        for (int i = 0; i < 2; i++) begin
            ref_mode = i ? 2'h0 : 2'h3;
            avg_log2 = i ? 3'h2 : 3'h0;
            temp_req = (i == 0);
            scan_last = 4'($unsigned($random(seed)) % 3);
            adc_result = 10'($random(seed));
            expect_scan(scan_last + 1);
            pin_low(5);
            convert_start_n = 1'b1;
            wait_eoc();
        end
        clock_mode_select = 2'h1;
        ref_mode = 2'h1; // external reference, no extra low time
        temp_req = 1'b1;
        scan_last = 4'h1;
        avg_log2 = 3'h1;
        expect_scan(2);
        command();
        for (int k = 0; k < 5; k++) begin
            pin_low(k == 0 ? 810 : 30);
            `CHK("power", 1'b1, adc_power)
            if (k > 0) `CHK("chan", 4'((k - 1) / 2), adc_channel)
            convert_start_n = 1'b1;
            wait_eoc();
            `CHK("power_off", 1'b0, adc_power)
        end
        dac_load_n = 1'b0;
        cyc(12);
        `CHK("dac_on", 1'b1, dac_transfer)
        dac_load_n = 1'b1;
        cyc(4);
        `CHK("dac_off", 1'b0, dac_transfer)
        clock_mode_select = 2'h3;
        temp_req = 1'b0;
        for (int b = 0; b < 2; b++) begin
            bias_keep_on = b[0];
            sar_word = 12'($random(seed));
            host.xfer(8'($random(seed)) | 8'h01, 8, 0, sar_word, 0, rx);
            `CHK("analog_on", 2'b00, {analog_off, bias_off})
            host.xfer(8'h00, 0, 16, sar_word, 0, rx);
            `CHK("dout", {4'h0, sar_word}, rx)
            host.xfer(8'h00, 16, 0, sar_word, 0, rx);
            `CHK("idle_off", {1'b1, !bias_keep_on}, {analog_off, bias_off})
        end
        temp_req = 1'b1;
        host.xfer(8'h81, 8, 0, sar_word, 0, rx);
        host.xfer(8'h00, 0, 192, sar_word, 0, rx);
        `CHK("temp_sclk", {4'h0, sar_word}, rx)
        cyc(5);
        `CHK("pending", 32'd0, 32'(exp_q.size()))
        end_sim();
    end
endmodule

bind acs_core acs_core_checker chk (
    .mclk(mclk), .rst(rst), .clock_mode_select(clock_mode_select), .conv_cmd(conv_cmd),
    .convert_start_n(convert_start_n), .cs_n(cs_n), .dac_load_n(dac_load_n), .eoc_n(eoc_n),
    .adc_channel(adc_channel), .adc_power(adc_power), .adc_convert(adc_convert), .fifo_we(fifo_we),
    .fifo_temp(fifo_temp), .fifo_data(fifo_data), .dac_transfer(dac_transfer));
